// >>> hdl/iopl_pkg.sv
// constants, register map and field layout for the latched i/o port block
// assumes a single 200 mhz system clock and an ahb-lite master reaching the registers
package iopl_pkg;

    // ****************************************************************
    // port geometry
    // ****************************************************************
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 12;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFS_DATA   = 12'h000; // latch write, mixed pin/latch read
    localparam logic [11:0] OFS_DIR    = 12'h004; // write-only direction
    localparam logic [11:0] OFS_PULLUP = 12'h008; // pull-up enables
    localparam logic [11:0] OFS_DRIVE  = 12'h00c; // high-drive enables

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_LATCH  = 8'h00;
    localparam logic [7:0] RST_DIR    = 8'h00; // 0 = input
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_DRIVE  = 8'h00;

    // pins that offer high drive: exactly eight
    localparam logic [7:0] DRIVE_CAPABLE = 8'hff;

    // ahb transfer type and size codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : iopl_pkg

// >>> hdl/iopl_sync.sv
// two flip-flop synchroniser for the pin inputs
// assumes pins are asynchronous to clk_sys
module iopl_sync #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // the first stage feeds only the second stage
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // iopl_sync

// >>> hdl/iopl_port.sv
// latched bidirectional i/o port with write-only direction, pull-up and drive control
// assumes an ahb-lite master with single word transfers on clk_sys; pins pass a synchroniser
//
// Operation
// [RQ1] after reset every bit is an input and stays so until software writes its direction bit to one.
// [RQ2] a bit's pull-up is attached only while the bit is an input, whatever its pull-up setting.
// [RQ3] reading the data register returns the synchronised pin level for every input bit.
// [RQ4] reading the data register returns the latch value for every output bit.
// [RQ5] the data register is written as a whole byte, so a read-modify-write puts pin levels into input latches.
// [RQ6] switching a bit from output to input leaves its latch unchanged.
// [RQ7] the direction register is write-only and reads back as zero.
// [RQ8] high drive is available on exactly eight pins.
// [RQ9] on small packages software routes interrupt one to the alternate pin via its edge select register.
// [RQ10] on small packages software keeps the level select bit of the unbonded interrupt pin at zero.
// [RQ11] on small packages software sets the unbonded pins as outputs.
// [RQ12] direction resets to input and pull-up and drive controls reset inactive.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
module iopl_port #(
    parameter int unsigned WIDTH = iopl_pkg::PORT_WIDTH
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // port pins
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] pin_pullup,
    output logic      [WIDTH-1:0] pin_high_drive
);

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    logic [WIDTH-1:0] pin_sync;

    iopl_sync #(
        .WIDTH    (WIDTH)
    ) u_sync (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // ****************************************************************
    // bus address phase capture
    // ****************************************************************
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic        rd_pend_q;
    logic        rd_pend_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic        take;

    // a transfer is accepted only when selected, nonseq and the bus is ready
    assign take = hsel && hready && (htrans == iopl_pkg::HTRANS_NONSEQ);

    always_comb
    begin
        wr_pend_d = take && hwrite;
        rd_pend_d = take && !hwrite;
        addr_d    = take ? haddr[11:0] : addr_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q    <= addr_d;
        end
    end

    // ****************************************************************
    // port registers
    // ****************************************************************
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] pullup_q;
    logic [WIDTH-1:0] pullup_d;
    logic [WIDTH-1:0] drive_q;
    logic [WIDTH-1:0] drive_d;

    // writes land in the data phase; the whole byte is always written
    always_comb
    begin
        latch_d  = latch_q;
        dir_d    = dir_q;
        pullup_d = pullup_q;
        drive_d  = drive_q;
        if (wr_pend_q)
        begin
            case (addr_q)
                iopl_pkg::OFS_DATA:   latch_d  = hwdata[WIDTH-1:0]; // [RQ5]
                iopl_pkg::OFS_DIR:    dir_d    = hwdata[WIDTH-1:0]; // [RQ1]
                iopl_pkg::OFS_PULLUP: pullup_d = hwdata[WIDTH-1:0];
                // non-capable pins never hold a drive bit
                iopl_pkg::OFS_DRIVE:  drive_d  = hwdata[WIDTH-1:0] & iopl_pkg::DRIVE_CAPABLE[WIDTH-1:0]; // [RQ8]
                default:              latch_d  = latch_q;
            endcase
        end
    end
    // a direction change alone never touches the latch, so outputs turned inputs keep their data [RQ6]

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            latch_q  <= iopl_pkg::RST_LATCH[WIDTH-1:0];
            dir_q    <= iopl_pkg::RST_DIR[WIDTH-1:0];    // [RQ12]
            pullup_q <= iopl_pkg::RST_PULLUP[WIDTH-1:0]; // [RQ12]
            drive_q  <= iopl_pkg::RST_DRIVE[WIDTH-1:0];  // [RQ12]
        end
        else
        begin
            latch_q  <= latch_d;
            dir_q    <= dir_d;
            pullup_q <= pullup_d;
            drive_q  <= drive_d;
        end
    end

    // ****************************************************************
    // read data and pin drive
    // ****************************************************************
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic [WIDTH-1:0] oe_q;
    logic [WIDTH-1:0] oe_d;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;
    logic [WIDTH-1:0] pu_q;
    logic [WIDTH-1:0] pu_d;
    logic [WIDTH-1:0] hd_q;
    logic [WIDTH-1:0] hd_d;

    // mix pin and latch per bit according to direction
    function automatic logic [WIDTH-1:0] port_view(input logic [WIDTH-1:0] dir,
                                                    input logic [WIDTH-1:0] lat,
                                                    input logic [WIDTH-1:0] pin);
        port_view = (dir & lat) | (~dir & pin); // [RQ3] [RQ4]
    endfunction

    // read data is registered at the address phase so it is ready one cycle later
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (take && !hwrite)
        begin
            case (haddr[11:0])
                iopl_pkg::OFS_DATA:   rdata_d[WIDTH-1:0] = port_view(dir_d, latch_d, pin_sync);
                iopl_pkg::OFS_DIR:    rdata_d = 32'h0000_0000; // [RQ7]
                iopl_pkg::OFS_PULLUP: rdata_d[WIDTH-1:0] = pullup_d;
                iopl_pkg::OFS_DRIVE:  rdata_d[WIDTH-1:0] = drive_d;
                default:              rdata_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
        oe_d  = dir_d;                 // [RQ1]
        out_d = latch_d;
        pu_d  = pullup_d & ~dir_d;     // [RQ2]
        hd_d  = drive_d & dir_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rdata_q <= 32'h0000_0000;
            oe_q    <= '0;
            out_q   <= '0;
            pu_q    <= '0;
            hd_q    <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
            oe_q    <= oe_d;
            out_q   <= out_d;
            pu_q    <= pu_d;
            hd_q    <= hd_d;
        end
    end

    // zero wait states, always okay; outputs straight from flops
    assign hrdata         = rdata_q;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign pin_out        = out_q;
    assign pin_oe         = oe_q;
    assign pin_pullup     = pu_q;
    assign pin_high_drive = hd_q;

    // rd_pend_q marks a read data phase; kept for symmetry with writes
    logic unused_ok;
    assign unused_ok = rd_pend_q ^ (|hsize);

endmodule // iopl_port

// >>> bench/iopl_port_checker.sv
// assertions on the latched i/o port, seen from its ports
// assumes bound into iopl_port; srst is synchronous
module iopl_port_checker #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input wire logic             clk_sys,
    input wire logic             srst,
    // ahb-lite
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pin_pullup,
    input wire logic [WIDTH-1:0] pin_high_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic             rd_q, rd_d, wr_q, wr_d;
    logic [11:0]      a_q, a_d;
    logic [3:0]       rs_q, rs_d;
    logic [WIDTH-1:0] d_q, d_d;
    // data phase tracker; reset history masks the synchroniser flush
    always_comb
    begin
        rd_d = hsel && hready && htrans == iopl_pkg::HTRANS_NONSEQ;
        wr_d = rd_d && hwrite;
        rd_d = rd_d && !hwrite;
        a_d  = haddr[11:0];
        d_d  = hwdata[WIDTH-1:0];
        rs_d = {rs_q[2:0], srst};
    end
    always_ff @(posedge clk_sys)
    begin
        rd_q <= rd_d;
        wr_q <= wr_d;
        a_q  <= a_d;
        d_q  <= d_d;
        rs_q <= rs_d;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_RESET_INPUT: assert property ($fell(srst) |-> pin_oe == 8'h00 && pin_pullup == 8'h00
        && pin_high_drive == 8'h00) else $error("port not idle input after reset");
    AST_PULLUP_INPUT: assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pull-up on output");
    AST_DRIVE_PINS: assert property ((pin_high_drive & ~(pin_oe & iopl_pkg::DRIVE_CAPABLE)) == 8'h00)
        else $error("high drive on wrong pin");
    AST_READ_INPUT: assert property (rd_q && a_q == iopl_pkg::OFS_DATA && rs_q == 4'h0 && $stable(pin_oe)
        && pin_in == $past(pin_in, 1) && pin_in == $past(pin_in, 2) && pin_in == $past(pin_in, 3)
        |-> ((hrdata[WIDTH-1:0] ^ pin_in) & ~pin_oe) == 8'h00) else $error("input bit not pin level");
    AST_READ_OUTPUT: assert property (rd_q && a_q == iopl_pkg::OFS_DATA && $stable(pin_oe) && $stable(pin_out)
        |-> ((hrdata[WIDTH-1:0] ^ pin_out) & pin_oe) == 8'h00) else $error("output bit not latch");
    AST_DIR_NO_READ: assert property (rd_q && a_q == iopl_pkg::OFS_DIR |-> hrdata == 32'h0)
        else $error("direction readable");
    AST_DIR_WRITE: assert property (wr_q && a_q == iopl_pkg::OFS_DIR |=> pin_oe == d_q)
        else $error("direction write lost");
    AST_LATCH_WRITE: assert property (wr_q && a_q == iopl_pkg::OFS_DATA |=> pin_out == d_q)
        else $error("latch byte write lost");
    AST_LATCH_HOLD: assert property (!(wr_q && a_q == iopl_pkg::OFS_DATA) |=> $stable(pin_out))
        else $error("latch changed without write");
    AST_PULLUP_WRITE: assert property (wr_q && a_q == iopl_pkg::OFS_PULLUP |=> pin_pullup == (d_q & ~pin_oe))
        else $error("pull-up write wrong");
    AST_OKAY: assert property (hreadyout && !hresp) else $error("slave not ready or not okay");
endmodule // iopl_port_checker

bind iopl_port iopl_port_checker #(.WIDTH(WIDTH)) u_chk (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_high_drive(pin_high_drive));

// >>> bench/iopl_pin_model.sv
// behavioural pin circuitry on the far side of the port
// assumes the bench gives the outside drive per pin
module iopl_pin_model (
    // clock
    input wire logic       clk_sys,
    // port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    // outside drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic     [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // interrupt-one routing and its level select sit outside this port; software leaves them as required
    logic [7:0] flt_q = 8'h00;
    // a pin nobody drives or pulls wanders, so no stale level can pass; plain always keeps the start value legal
    always @(posedge clk_sys)
    begin
        flt_q <= ~pin_in;
    end
    // port drive wins, then outside drive, then the pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | flt_q));
endmodule // iopl_pin_model

// >>> bench/testbench.sv
// self-checking bench for the latched i/o port over ahb-lite
// assumes the one slave's hreadyout is the bus hready
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, srst = 1'b1, hsel = 1'b1, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = iopl_pkg::HSIZE_WORD;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_high_drive, ext_en = 8'hff, ext_val = 8'ha5;
    int          fails = 0, n_compared = 0;
    assign hready = hreadyout;
    always #2.5 clk_sys = ~clk_sys;
    iopl_port uut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_high_drive(pin_high_drive));
    iopl_pin_model u_pins (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // one single ahb transfer; the master waits for hready, never a fixed count
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
        htrans <= iopl_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task automatic summarize;
    begin
        $display("TB: %0d mismatches in %0d compares", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // main sequence; pin outputs are looked at once the write edge has landed
    initial
    begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        chk({8'h0, pin_oe, pin_pullup, pin_high_drive}, 32'h0);
        xfer(1'b1, iopl_pkg::OFS_DATA, 32'hffffff3c);
        xfer(1'b0, iopl_pkg::OFS_DATA, 32'h0);
        chk(rd, 32'ha5);
        xfer(1'b1, iopl_pkg::OFS_DIR, 32'hf0);
        ext_en <= 8'h0f;
        xfer(1'b0, iopl_pkg::OFS_DATA, 32'h0);
        chk(rd, 32'h35);
        xfer(1'b0, iopl_pkg::OFS_DIR, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, iopl_pkg::OFS_DATA, 32'h0);
        xfer(1'b1, iopl_pkg::OFS_DATA, rd | 32'h40); // bit set as read then whole-byte write
        xfer(1'b1, iopl_pkg::OFS_DIR, 32'h0);
        xfer(1'b1, iopl_pkg::OFS_DIR, 32'hff); // every pin an output, as software does for unbonded pins
        xfer(1'b0, iopl_pkg::OFS_DATA, 32'h0);
        chk(rd, 32'h75);
        chk({16'h0, pin_oe, pin_out}, 32'hff75);
        xfer(1'b1, iopl_pkg::OFS_PULLUP, 32'hff);
        #1;
        chk({24'h0, pin_pullup}, 32'h0);
        xfer(1'b1, iopl_pkg::OFS_DRIVE, 32'hff);
        #1;
        chk({24'h0, pin_high_drive}, 32'hff);
        xfer(1'b1, iopl_pkg::OFS_DIR, 32'h0f);
        #1;
        chk({16'h0, pin_pullup, pin_high_drive}, 32'hf00f);
        xfer(1'b1, 12'h010, 32'hff);
        xfer(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, iopl_pkg::OFS_DATA, 32'h0);
        chk(rd, 32'hf5);
        // mid-run reset with the low four pins outputs and the pull-up and drive registers all set; wait out the synchroniser flush after release
        srst <= 1'b1;
        ext_en <= 8'hff;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({pin_out, pin_oe, pin_pullup, pin_high_drive}, 32'h0);
        xfer(1'b0, iopl_pkg::OFS_DATA, 32'h0);
        chk(rd, 32'ha5);
        summarize();
    end
    // watchdog well beyond the fewer than a hundred cycles the sequence needs
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        fails++;
        summarize();
    end
endmodule // testbench
